// *** logic/preamp_ctrl_pkg.sv ***
package preamp_ctrl_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int CLK_MHZ        = 100;                // mclk rate
  localparam int SCL_PERIOD_NS  = 10000;              // host link clock period
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;
  localparam int CLAMP_W0_NS    = 330;                // 0.33 us
  localparam int CLAMP_W1_NS    = 660;                // 0.66 us
  localparam int CLAMP_W2_NS    = 1000;               // 1 us
  localparam int CLAMP_W3_NS    = 1330;               // 1.33 us
  localparam logic [7:0] CLAMP_W0_CYC = 8'(CLAMP_W0_NS * CLK_MHZ / 1000);
  localparam logic [7:0] CLAMP_W1_CYC = 8'(CLAMP_W1_NS * CLK_MHZ / 1000);
  localparam logic [7:0] CLAMP_W2_CYC = 8'(CLAMP_W2_NS * CLK_MHZ / 1000);
  localparam logic [7:0] CLAMP_W3_CYC = 8'(CLAMP_W3_NS * CLK_MHZ / 1000);

  // ****************************************************
  // sub-addresses
  // ****************************************************
  localparam logic [7:0] SUB_CONTRAST = 8'h01;
  localparam logic [7:0] SUB_BRIGHT   = 8'h02;
  localparam logic [7:0] SUB_DRIVE1   = 8'h03;
  localparam logic [7:0] SUB_DRIVE2   = 8'h04;
  localparam logic [7:0] SUB_DRIVE3   = 8'h05;
  localparam logic [7:0] SUB_OVERLAY  = 8'h07;
  localparam logic [7:0] SUB_CLAMP    = 8'h08;
  localparam logic [7:0] SUB_MISC     = 8'h09;
  localparam logic [7:0] SUB_CUT1     = 8'h0a;
  localparam logic [7:0] SUB_CUT2     = 8'h0b;
  localparam logic [7:0] SUB_CUT3     = 8'h0c;
  localparam logic [7:0] SUB_BW       = 8'h0d;

  // ****************************************************
  // reset values and field positions
  // ****************************************************
  localparam logic [7:0] RST_LEVEL   = 8'hb4;
  localparam logic [3:0] RST_OVERLAY = 4'h9;
  localparam logic [7:0] RST_CLAMP   = 8'h04;
  localparam logic [7:0] RST_MISC    = 8'h1c;
  localparam logic [5:0] RST_BW      = 6'h07;
  localparam int CLAMP_TRIG_BIT = 0;
  localparam int CLAMP_EDGE_BIT = 1;
  localparam int CLAMP_WID_LSB  = 2;
  localparam int CLAMP_EXT_BIT  = 4;
  localparam int CLAMP_FBP_BIT  = 5;
  localparam int CLAMP_FOC_BIT  = 6;
  localparam int CLAMP_SRC_BIT  = 7;
  localparam int MISC_B2_BIT    = 2;
  localparam int MISC_B3_BIT    = 3;
  localparam int MISC_LIGHT_BIT = 5;
  localparam int MISC_DARK_BIT  = 6;
  localparam int BW_TEST_LSB    = 4;
  localparam logic [7:0] CUTOFF_MIN  = 8'h28;         // decimal 40
  localparam logic [7:0] LEVEL_BANLO = 8'h00;
  localparam logic [7:0] LEVEL_BANHI = 8'hff;

  // ****************************************************
  // host wishbone map
  // ****************************************************
  localparam logic [3:0] WB_CMD_ADDR  = 4'h0;
  localparam logic [3:0] WB_STAT_ADDR = 4'h4;
  localparam int CMD_SUB_LSB  = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_GO_BIT   = 31;

  // ****************************************************
  // state types
  // ****************************************************
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_SUB, D_DATA, D_ACK, D_IGNORE} dev_state_e;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} host_state_e;

endpackage

// *** logic/preamp_link_if.sv ***
`timescale 1ns/1ns
interface preamp_link_if;
  logic sclHostO;   // host clock out value
  logic sclHostOe;  // host pulls clock
  logic sdaHostO;   // host data out value
  logic sdaHostOe;  // host pulls data
  logic sdaDevO;    // device data out value
  logic sdaDevOe;   // device pulls data
  logic scl;        // resolved clock wire
  logic sda;        // resolved data wire

  // open-drain wires with pull-ups
  assign scl = sclHostOe ? sclHostO : 1'b1;
  assign sda = (sdaHostOe ? sdaHostO : 1'b1) & (sdaDevOe ? sdaDevO : 1'b1);

  modport device (input scl, input sda, output sdaDevO, output sdaDevOe);
  modport host (input scl, input sda, output sclHostO, output sclHostOe,
                output sdaHostO, output sdaHostOe);
endinterface

// *** logic/preamp_regs_dev.sv ***
// Behaviour
// - contrast at 01, reset b4, top fe
// - three drives at 03-05, reset b4
// - master never writes 00 or ff there
// - three cut-off levels 0a-0c, reset b4
// - master never writes cut-off below 40
// - four-bit bandwidth at 0d, reset 07
// - slow edges: master programs bandwidth zero
// - clamp b0 picks hsync or blanking trigger
// - clamp b1 picks trailing or leading edge
// - clamp b3:b2 set generated pulse width
// - clamp b4 passes external clamp pulse
// - clamp b5/b6 force clamps, test only
// - clamp b7 picks output clamp source
// - master sets misc b3=0, b2=1 after power-on; host only refuses misc writes with b3=1 or b2=0
// - misc b5/b6 select light/dark grey
// - bandwidth b5:b4 route converter for test
`timescale 1ns/1ns
module preamp_regs_dev import preamp_ctrl_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // bus address, arbitrary value
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // serial link
  preamp_link_if.device   link,
  // video timing pins
  input  wire logic       hsyncIn,
  input  wire logic       blankingIn,
  input  wire logic       extClampIn,
  // control values
  output logic [7:0]      contrastLevel,
  output logic [7:0]      brightnessLevel,
  output logic [7:0]      channelDrive1,
  output logic [7:0]      channelDrive2,
  output logic [7:0]      channelDrive3,
  output logic [3:0]      overlayContrast,
  output logic [7:0]      clampPulseConfig,
  output logic [7:0]      miscConfig,
  output logic [7:0]      cutoffLevel1,
  output logic [7:0]      cutoffLevel2,
  output logic [7:0]      cutoffLevel3,
  output logic [3:0]      bandwidthSetting,
  // derived controls
  output logic            backPorchClampPulse,
  output logic            outputClampPulse,
  output logic            greyLight,
  output logic            greyDark,
  output logic            blankFromBw,
  output logic            blankFromBwInv
);

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [4:0] syncA;   // first stage, read only by syncB
  logic [4:0] syncB;   // second stage
  logic       sclS;    // synchronised link clock
  logic       sdaS;    // synchronised link data
  logic       hsyncS;  // synchronised hsync
  logic       blankS;  // synchronised blanking
  logic       extS;    // synchronised external clamp

  // two flops on every outside input
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // idle levels: link wires high, video pins low
      syncA <= 5'h18;
      syncB <= 5'h18;
    end else begin
      syncA <= {link.scl, link.sda, hsyncIn, blankingIn, extClampIn};
      syncB <= syncA;
    end
  end
  assign {sclS, sdaS, hsyncS, blankS, extS} = syncB;

  // ****************************************************
  // link edge and condition detection
  // ****************************************************
  logic sclPrev;   // clock last cycle
  logic sdaPrev;   // data last cycle
  logic sclRise;   // clock rising
  logic sclFall;   // clock falling
  logic startCond; // data falls, clock high
  logic stopCond;  // data rises, clock high

  // history of the synchronised wires
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end
  assign sclRise   = sclS & ~sclPrev;
  assign sclFall   = ~sclS & sclPrev;
  assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;

  // ****************************************************
  // link receiver
  // ****************************************************
  dev_state_e state_reg;    // receiver state
  dev_state_e afterAck_reg; // state after acknowledge
  logic [7:0] shift_reg;    // incoming byte
  logic [2:0] bitCnt_reg;   // bits taken
  logic       byteFull_reg; // byte waiting for ack slot
  logic       ackOk_reg;    // acknowledge this byte
  logic [7:0] subAddr_reg;  // register pointer
  logic       wrStb;        // data byte complete
  logic [7:0] byteNow;      // byte incl. current bit
  logic       sdaOe_reg;    // pulling data low

  assign byteNow = {shift_reg[6:0], sdaS};
  assign wrStb   = sclRise && state_reg == D_DATA && bitCnt_reg == 3'h7;

  // serial byte engine
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= D_IDLE;
      afterAck_reg <= D_IDLE;
      shift_reg    <= 8'h00;
      bitCnt_reg   <= 3'h0;
      byteFull_reg <= 1'b0;
      ackOk_reg    <= 1'b0;
      subAddr_reg  <= 8'h00;
      sdaOe_reg    <= 1'b0;
    end else if (startCond) begin
      // (repeated) start: expect address
      state_reg    <= D_ADDR;
      bitCnt_reg   <= 3'h0;
      byteFull_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else if (stopCond) begin
      // stop: back to idle
      state_reg    <= D_IDLE;
      byteFull_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else if (sclRise) begin
      case (state_reg)
        D_ADDR, D_SUB, D_DATA: begin
          shift_reg  <= byteNow;
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (bitCnt_reg == 3'h7) begin
            byteFull_reg <= 1'b1;
            ackOk_reg    <= 1'b1;
            case (state_reg)
              D_ADDR: begin
                // only write transfers to this address
                ackOk_reg    <= byteNow == {DEV_ADDR, 1'b0};
                afterAck_reg <= D_SUB;
              end
              D_SUB: begin
                subAddr_reg  <= byteNow;
                afterAck_reg <= D_DATA;
              end
              default: begin
                // further bytes go to the next sub-address
                subAddr_reg  <= subAddr_reg + 8'h01;
                afterAck_reg <= D_DATA;
              end
            endcase
          end
        end
        default: begin
          // other states ignore data bits
        end
      endcase
    end else if (sclFall) begin
      if (byteFull_reg) begin
        // open acknowledge slot or drop out
        byteFull_reg <= 1'b0;
        sdaOe_reg    <= ackOk_reg;
        state_reg    <= ackOk_reg ? D_ACK : D_IGNORE;
      end else if (state_reg == D_ACK) begin
        // release data after acknowledge bit
        sdaOe_reg  <= 1'b0;
        bitCnt_reg <= 3'h0;
        state_reg  <= afterAck_reg;
      end
    end
  end
  assign link.sdaDevOe = sdaOe_reg;
  assign link.sdaDevO  = 1'b0;

  // ****************************************************
  // register bank
  // ****************************************************
  logic [5:0] bwByte_reg; // bandwidth plus test route

  // write on completion of the data byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      contrastLevel    <= RST_LEVEL;
      brightnessLevel  <= RST_LEVEL;
      channelDrive1    <= RST_LEVEL;
      channelDrive2    <= RST_LEVEL;
      channelDrive3    <= RST_LEVEL;
      overlayContrast  <= RST_OVERLAY;
      clampPulseConfig <= RST_CLAMP;
      miscConfig       <= RST_MISC;
      cutoffLevel1     <= RST_LEVEL;
      cutoffLevel2     <= RST_LEVEL;
      cutoffLevel3     <= RST_LEVEL;
      bwByte_reg       <= RST_BW;
    end else if (wrStb) begin
      case (subAddr_reg)
        SUB_CONTRAST: contrastLevel    <= byteNow;
        SUB_BRIGHT:   brightnessLevel  <= byteNow;
        SUB_DRIVE1:   channelDrive1    <= byteNow;
        SUB_DRIVE2:   channelDrive2    <= byteNow;
        SUB_DRIVE3:   channelDrive3    <= byteNow;
        SUB_OVERLAY:  overlayContrast  <= byteNow[3:0];
        SUB_CLAMP:    clampPulseConfig <= byteNow;
        SUB_MISC:     miscConfig       <= byteNow;
        SUB_CUT1:     cutoffLevel1     <= byteNow;
        SUB_CUT2:     cutoffLevel2     <= byteNow;
        SUB_CUT3:     cutoffLevel3     <= byteNow;
        SUB_BW:       bwByte_reg       <= byteNow[5:0];
        default: begin
          // unused sub-address: byte acknowledged, dropped
        end
      endcase
    end
  end
  assign bandwidthSetting = bwByte_reg[3:0];

  // ****************************************************
  // back-porch clamp pulse generator
  // ****************************************************
  logic       trigNow;      // selected trigger level
  logic       trigPrev_reg; // trigger last cycle
  logic       trigEdge;     // chosen edge seen
  logic [7:0] width;        // pulse length in cycles
  logic [7:0] pulseCnt_reg; // cycles left in pulse
  logic       internalBp;   // internal clamp pulse

  assign trigNow = clampPulseConfig[CLAMP_TRIG_BIT] ? blankS : hsyncS;
  assign trigEdge = clampPulseConfig[CLAMP_EDGE_BIT] ?
                    (trigNow & ~trigPrev_reg) : (~trigNow & trigPrev_reg);

  // width lookup
  always_comb begin
    case (clampPulseConfig[CLAMP_WID_LSB +: 2])
      2'h0:    width = CLAMP_W0_CYC;
      2'h1:    width = CLAMP_W1_CYC;
      2'h2:    width = CLAMP_W2_CYC;
      default: width = CLAMP_W3_CYC;
    endcase
  end

  // pulse counter restarts on every chosen edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trigPrev_reg <= 1'b0;
      pulseCnt_reg <= 8'h00;
    end else begin
      trigPrev_reg <= trigNow;
      if (trigEdge) begin
        pulseCnt_reg <= width;
      end else if (pulseCnt_reg != 8'h00) begin
        pulseCnt_reg <= pulseCnt_reg - 8'h01;
      end
    end
  end
  assign internalBp = clampPulseConfig[CLAMP_EXT_BIT] ? extS : (pulseCnt_reg != 8'h00);

  // ****************************************************
  // derived outputs
  // ****************************************************
  // clamp outputs, test forces and background decode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      backPorchClampPulse <= 1'b0;
      outputClampPulse    <= 1'b0;
      greyLight           <= 1'b0;
      greyDark            <= 1'b0;
      blankFromBw         <= 1'b0;
      blankFromBwInv      <= 1'b0;
    end else begin
      backPorchClampPulse <= clampPulseConfig[CLAMP_FBP_BIT] | internalBp;
      outputClampPulse    <= clampPulseConfig[CLAMP_FOC_BIT] |
                             (clampPulseConfig[CLAMP_SRC_BIT] ? internalBp : blankS);
      greyLight <= miscConfig[MISC_LIGHT_BIT] & ~miscConfig[MISC_DARK_BIT];
      greyDark  <= miscConfig[MISC_DARK_BIT] & ~miscConfig[MISC_LIGHT_BIT];
      blankFromBw    <= bwByte_reg[BW_TEST_LSB +: 2] == 2'h1;
      blankFromBwInv <= bwByte_reg[BW_TEST_LSB +: 2] == 2'h2;
    end
  end

endmodule

// *** logic/preamp_regs_host.sv ***
`timescale 1ns/1ns
module preamp_regs_host import preamp_ctrl_pkg::*; #(
  parameter logic [6:0] DEV_ADDR    = 7'h2a,           // device address, arbitrary
  parameter int         QUARTER_CYC = SCL_QUARTER_CYC  // quarter of link clock
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // serial link
  preamp_link_if.host      link
);

  // ****************************************************
  // data line synchroniser
  // ****************************************************
  logic sdaA; // first stage
  logic sdaS; // second stage

  // two flops before the ack sample
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdaA <= 1'b1;
      sdaS <= 1'b1;
    end else begin
      sdaA <= link.sda;
      sdaS <= sdaA;
    end
  end

  // ****************************************************
  // quarter-bit tick divider
  // ****************************************************
  logic [15:0] divCnt_reg; // divider count
  logic        tick;       // one-cycle quarter enable
  assign tick = divCnt_reg == 16'(QUARTER_CYC - 1);

  // free-running divider
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_reg <= 16'h0000;
    end else begin
      divCnt_reg <= tick ? 16'h0000 : divCnt_reg + 16'h0001;
    end
  end

  // ****************************************************
  // command check and wishbone slave
  // ****************************************************
  logic        busy_reg;    // transfer running
  logic        nack_reg;    // last transfer not acknowledged
  logic        reject_reg;  // last command refused
  logic [15:0] cmd_reg;     // data and sub-address
  logic        go;          // accepted start request
  logic        badCmd;      // command breaks a device limit
  logic [7:0]  cSub;        // requested sub-address
  logic [7:0]  cDat;        // requested data
  logic        doneStb;     // transfer finished

  assign cSub = wb_dat_i[CMD_SUB_LSB +: 8];
  assign cDat = wb_dat_i[CMD_DATA_LSB +: 8];

  // refuse values the device must never see
  always_comb begin
    badCmd = 1'b0;
    case (cSub)
      SUB_CONTRAST, SUB_DRIVE1, SUB_DRIVE2, SUB_DRIVE3:
        badCmd = cDat == LEVEL_BANLO || cDat == LEVEL_BANHI;
      SUB_CUT1, SUB_CUT2, SUB_CUT3:
        badCmd = cDat < CUTOFF_MIN;
      SUB_CLAMP:
        badCmd = cDat[CLAMP_FBP_BIT] | cDat[CLAMP_FOC_BIT];
      SUB_MISC:
        badCmd = cDat[MISC_B3_BIT] | ~cDat[MISC_B2_BIT];
      default: badCmd = 1'b0;
    endcase
  end

  assign go = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == WB_CMD_ADDR
              && wb_sel_i[3] && wb_dat_i[CMD_GO_BIT] && !busy_reg;

  // one-cycle answer, reads of status and command
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      cmd_reg    <= 16'h0000;
      reject_reg <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (doneStb) begin
        busy_reg <= 1'b0;
      end
      if (go) begin
        reject_reg <= badCmd;
        busy_reg   <= !badCmd;
        if (!badCmd) begin
          cmd_reg <= wb_dat_i[15:0];
        end
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          WB_CMD_ADDR:  wb_dat_o <= {16'h0000, cmd_reg};
          WB_STAT_ADDR: wb_dat_o <= {29'h00000000, reject_reg, nack_reg, busy_reg};
          default:      wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************
  // link master: address, sub-address, data
  // ****************************************************
  host_state_e state_reg;  // sequencer state
  logic [1:0]  q_reg;      // quarter within bit
  logic [3:0]  bit_reg;    // bit index, 8 is ack
  logic [1:0]  byte_reg;   // byte index
  logic [7:0]  shift_reg;  // outgoing byte
  logic        sclOe_reg;  // pulling clock low
  logic        sdaOe_reg;  // pulling data low

  assign doneStb = tick && state_reg == M_STOP && q_reg == 2'h3;

  // bit sequencer, one step per tick
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= M_IDLE;
      q_reg     <= 2'h0;
      bit_reg   <= 4'h0;
      byte_reg  <= 2'h0;
      shift_reg <= 8'h00;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      nack_reg  <= 1'b0;
    end else if (state_reg == M_IDLE) begin
      if (busy_reg) begin
        state_reg <= M_START;
        q_reg     <= 2'h0;
        nack_reg  <= 1'b0;
      end
    end else if (tick) begin
      q_reg <= q_reg + 2'h1;
      case (state_reg)
        M_START: begin
          if (q_reg == 2'h1) sdaOe_reg <= 1'b1;
          if (q_reg == 2'h3) begin
            sclOe_reg <= 1'b1;
            state_reg <= M_BIT;
            bit_reg   <= 4'h0;
            byte_reg  <= 2'h0;
            shift_reg <= {DEV_ADDR, 1'b0};
          end
        end
        M_BIT: begin
          case (q_reg)
            2'h0: sdaOe_reg <= bit_reg[3] ? 1'b0 : ~shift_reg[7];
            2'h1: sclOe_reg <= 1'b0;
            2'h2: if (bit_reg[3]) nack_reg <= sdaS;
            default: begin
              sclOe_reg <= 1'b1;
              if (!bit_reg[3]) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg   <= bit_reg + 4'h1;
              end else if (nack_reg || byte_reg == 2'h2) begin
                state_reg <= M_STOP;
              end else begin
                // sub-address then data byte
                byte_reg  <= byte_reg + 2'h1;
                bit_reg   <= 4'h0;
                shift_reg <= byte_reg == 2'h0 ? cmd_reg[7:0] : cmd_reg[15:8];
              end
            end
          endcase
        end
        M_STOP: begin
          case (q_reg)
            2'h0: sdaOe_reg <= 1'b1;
            2'h1: sclOe_reg <= 1'b0;
            2'h2: sdaOe_reg <= 1'b0;
            default: state_reg <= M_IDLE;
          endcase
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end
  assign link.sclHostOe = sclOe_reg;
  assign link.sdaHostOe = sdaOe_reg;
  assign link.sclHostO  = 1'b0;
  assign link.sdaHostO  = 1'b0;

endmodule

// *** testbench/preamp_link_monitor.sv ***
`timescale 1ns/1ns
module preamp_link_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link signals
  input wire logic sclHostO,
  input wire logic sclHostOe,
  input wire logic sdaHostO,
  input wire logic sdaHostOe,
  input wire logic sdaDevO,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************************
  // link checks
  // ****************************************************
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // device lets go of data about one bit time after pulling it
  sequence s_ack_end; ##[10:40] $fell(sdaDevOe); endsequence
  // start holds data low while the clock stays high
  sequence s_start_hold; ##[8:12] $rose(sclHostOe); endsequence
  property p_scl_val; sclHostO == 1'b0; endproperty
  property p_sda_val; sdaHostO == 1'b0 && sdaDevO == 1'b0; endproperty
  property p_ack_rise; $rose(sdaDevOe) |-> !scl; endproperty
  property p_ack_hold; scl && $past(scl) |-> $stable(sdaDevOe); endproperty
  property p_ack_len; $rose(sdaDevOe) |-> s_ack_end; endproperty
  property p_scl_low; $rose(sclHostOe) |-> sclHostOe [*8]; endproperty
  property p_scl_high; $fell(sclHostOe) |-> !sclHostOe [*8]; endproperty
  property p_start; $rose(sdaHostOe) && scl |-> s_start_hold; endproperty
  a_scl_val: assert property (p_scl_val) else $error("host clock value not low");
  a_sda_val: assert property (p_sda_val) else $error("data value not low");
  a_ack_rise: assert property (p_ack_rise) else $error("ack began with clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("ack moved with clock high");
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  a_start: assert property (p_start) else $error("start hold wrong");
endmodule

// *** testbench/rgb_preamp_control_registers_test.sv ***
`timescale 1ns/1ns
module rgb_preamp_control_registers_test import preamp_ctrl_pkg::*; ;
  // ****************************************************
  // stimulus and observed signals
  // ****************************************************
  logic mclk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, hs = 0, bl = 0, ec = 0;
  logic [3:0]  adr = 0, sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic        ack, bp, oc, gl, gd, fb, fbi;
  logic [7:0]  con, dr1, dr2, dr3, cut1, cfg, misc, bri, cut2, cut3;
  logic [3:0]  ovl, bw;
  int          bad_count = 0, num_checks = 0, cyc_n = 0;
  preamp_link_if u_preamp_link_if ();
  preamp_regs_host #(.QUARTER_CYC(5)) u_preamp_regs_host (.mclk(mclk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(u_preamp_link_if));
  preamp_regs_dev u_preamp_regs_dev (.mclk(mclk), .rst_b(rst_b), .link(u_preamp_link_if),
    .hsyncIn(hs), .blankingIn(bl), .extClampIn(ec), .contrastLevel(con),
    .brightnessLevel(bri), .channelDrive1(dr1), .channelDrive2(dr2), .channelDrive3(dr3),
    .overlayContrast(ovl), .clampPulseConfig(cfg), .miscConfig(misc), .cutoffLevel1(cut1),
    .cutoffLevel2(cut2), .cutoffLevel3(cut3), .bandwidthSetting(bw), .backPorchClampPulse(bp),
    .outputClampPulse(oc), .greyLight(gl), .greyDark(gd), .blankFromBw(fb),
    .blankFromBwInv(fbi));
  preamp_link_monitor u_preamp_link_monitor (.mclk(mclk), .rst_b(rst_b),
    .sclHostO(u_preamp_link_if.sclHostO), .sclHostOe(u_preamp_link_if.sclHostOe),
    .sdaHostO(u_preamp_link_if.sdaHostO), .sdaHostOe(u_preamp_link_if.sdaHostOe),
    .sdaDevO(u_preamp_link_if.sdaDevO), .sdaDevOe(u_preamp_link_if.sdaDevOe),
    .scl(u_preamp_link_if.scl), .sda(u_preamp_link_if.sda));
  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  // ****************************************************
  // shared tasks
  // ****************************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack is seen at a rising edge
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0; sel <= 0;
  endtask
  // send one register write over the link and wait until idle
  task put(input logic [7:0] s, input logic [7:0] d, output logic [31:0] st);
    logic [31:0] q;
    wb(1'b1, WB_CMD_ADDR, {1'b1, 15'h0, d, s}, q);
    do wb(1'b0, WB_STAT_ADDR, 32'h0, st); while (st[0] === 1'b1);
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task t_write;
    logic [31:0] st;
    chk({con, dr1, dr2, dr3}, {4{RST_LEVEL}});
    chk({cut1, cfg, misc, ovl, bw}, {RST_LEVEL, RST_CLAMP, RST_MISC, RST_OVERLAY, 4'h7});
    chk({bri, cut2, cut3}, {3{RST_LEVEL}});
    put(SUB_MISC, 8'h24, st);
    chk({st[2], gl, gd}, 3'b010);
    put(SUB_MISC, 8'h44, st);
    chk({gl, gd}, 2'b01);
    put(SUB_CONTRAST, 8'hfe, st);
    for (int i = 0; i < 3; i++) put(SUB_DRIVE1 + 8'(i), 8'h01 + 8'(i), st);
    chk({con, dr1, dr2, dr3}, 32'hfe010203);
    put(SUB_BW, 8'h00, st);
    chk(bw, 4'h0);
    put(SUB_BW, 8'h1f, st);
    chk({bw, fb, fbi}, 6'h3e);
    put(SUB_BW, 8'h2f, st);
    chk({bw, fb, fbi}, 6'h3d);
    $display("test write done");
  endtask
  task t_refuse;
    logic [31:0] st;
    put(SUB_CONTRAST, 8'hff, st);
    chk({st[2], con}, 9'h1fe);
    put(SUB_DRIVE2, 8'h00, st);
    chk({st[2], dr2}, 9'h102);
    put(SUB_CUT1, 8'h27, st);
    chk({st[2], cut1}, {1'b1, RST_LEVEL});
    put(SUB_CUT1, CUTOFF_MIN, st);
    chk(cut1, CUTOFF_MIN);
    wb(1'b0, 4'h8, 32'h0, st);
    chk(st, 32'h0);
    $display("test refuse done");
  endtask
  task t_clamp;
    logic [31:0] st;
    int n;
    put(SUB_CLAMP, 8'h10, st);
    ec <= 1;
    repeat (8) @(negedge mclk);
    chk(bp, 1'b1);
    @(posedge mclk);
    ec <= 0;
    put(SUB_CLAMP, 8'h00, st);
    chk(bp, 1'b0);
    bl <= 1; hs <= 1;
    repeat (8) @(negedge mclk);
    chk({oc, bp}, 2'b10);
    @(posedge mclk);
    bl <= 0; hs <= 0;
    for (n = 0; n < 20 && bp !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 300 && bp === 1'b1; n++) @(negedge mclk);
    chk(n, CLAMP_W0_CYC);
    put(SUB_CLAMP, 8'h8f, st);
    bl <= 1;
    for (n = 0; n < 20 && bp !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 300 && bp === 1'b1; n++) @(negedge mclk);
    chk({oc, n[7:0]}, {1'b0, CLAMP_W3_CYC});
    $display("test clamp done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    repeat (6) @(posedge mclk);
    t_write();
    t_refuse();
    t_clamp();
    end_sim();
  end
endmodule
